// >>> esw_cfg.svh
`ifndef ESW_CFG_SVH
`define ESW_CFG_SVH

// ****************************************************************
// serial command addresses (14-bit field of a command frame)
// ****************************************************************
`define ADDR_ERROR_STATUS 14'h335A
`define ADDR_ANGLE 14'h3FFF
`define ADDR_CLEAR_ERROR 14'h3380
`define ADDR_MASTER_RESET 14'h33A5
`define ADDR_NOP 14'h0000

// ****************************************************************
// frame layout
// ****************************************************************
`define FRAME_BITS 16
`define FRAME_RW_BIT 15
`define FRAME_READ 1'b1

// ****************************************************************
// error status word fields and reset value
// ****************************************************************
`define ESW_BUSY_BIT 4
`define ESW_BAD_ADDR_BIT 2
`define ESW_CLK_COUNT_BIT 1
`define ESW_PARITY_BIT 0
`define ESW_RESET 14'h0000
`define RESP_RESET 14'h0000

`endif

// >>> esw_pkg.sv
`default_nettype none

package esw_pkg;

    typedef logic [13:0] word14_t;

    typedef enum logic {
        MEAS_IDLE,
        MEAS_BUSY
    } meas_state_t;

    typedef struct packed {
        meas_state_t meas;
        logic bad_address_monitor_flag;
        logic clock_count_monitor_flag;
        logic parity_flag;
        word14_t resp;
        logic meas_start;
        logic meas_abort;
    } flags_state_t;

endpackage

`default_nettype wire

// >>> spi_frame_shifter.sv
`timescale 1ns/100ps
`default_nettype none

// mode 1 serial slave: miso changes on the rising sck edge, mosi is
// sampled on the falling edge; all pins are synchronous to clk
module spi_frame_shifter #(
    parameter int FRAME_BITS = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic [FRAME_BITS-1:0] tx_word,
    output logic [FRAME_BITS-1:0] rx_word,
    output logic [4:0] rx_count,
    output logic frame_end,
    output logic miso,
    output logic miso_oe
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic sck_q;
        logic ss_q;
        logic [FRAME_BITS-1:0] rx;
        logic [FRAME_BITS-1:0] tx;
        logic [4:0] cnt;
        logic frame_end;
        logic miso;
    } shift_state_t;

    shift_state_t s;
    shift_state_t next_s;

    // the counter saturates at 31, so a frame must be shorter than that
    if (FRAME_BITS < 2 || FRAME_BITS > 30) begin : g_bad_width
        $error("spi_frame_shifter: FRAME_BITS out of range");
    end

    always_comb begin
        next_s = s;
        next_s.sck_q = sck;
        next_s.ss_q = ss_n;
        next_s.frame_end = 1'b0;
        if (s.ss_q && !ss_n) begin
            next_s.tx = tx_word;
            next_s.cnt = 5'h00;
            next_s.miso = 1'b0;
        end else if (!ss_n) begin
            if (!s.sck_q && sck) begin
                next_s.miso = s.tx[FRAME_BITS-1];
                next_s.tx = {s.tx[FRAME_BITS-2:0], 1'b0};
            end
            if (s.sck_q && !sck) begin
                next_s.rx = {s.rx[FRAME_BITS-2:0], mosi};
                if (s.cnt != 5'h1F) begin
                    next_s.cnt = s.cnt + 5'h01;
                end
            end
        end
        if (!s.ss_q && ss_n) begin
            next_s.frame_end = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.sck_q <= 1'b0;
            s.ss_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rx_word = s.rx;
    assign rx_count = s.cnt;
    assign frame_end = s.frame_end;
    assign miso = s.miso;
    assign miso_oe = !s.ss_q;

endmodule
`default_nettype wire

// >>> sensor_error_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "esw_cfg.svh"

// Summary of operation
// - While an angle read is being processed the busy flag (bit 4) is 1.
// - When the measurement engine reports completion the busy flag is 0.
// - A stuck busy flag is cleared by the host's master reset command.
// - A command to an address that does not exist sets bit 2.
// - A frame with the wrong number of clock cycles sets bit 1.
// - A frame with the right clock count whose parity does not check sets bit 0.
// - Every response carries a flag reporting an earlier link error.
// - The error status word is read at serial address 0x335A.
module sensor_error_status_flags #(
    parameter int FRAME_BITS = `FRAME_BITS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    output logic miso_oe,
    output logic meas_start,
    output logic meas_abort,
    input wire logic meas_done,
    input wire esw_pkg::word14_t angle_word,
    output esw_pkg::word14_t error_status_word,
    output logic communication_error_flag
);
    import esw_pkg::*;

    // the command decode assumes a 16-bit frame with a 14-bit field
    if (FRAME_BITS != 16) begin : g_bad_frame
        $error("sensor_error_status_flags: FRAME_BITS must be 16");
    end

    // ****************************************************************
    // serial frame shifter
    // ****************************************************************
    logic [15:0] rx_word;
    logic [15:0] tx_word;
    logic [4:0] rx_count;
    logic frame_end;

    spi_frame_shifter #(
        .FRAME_BITS(FRAME_BITS)
    ) u_shifter (
        .clk(clk),
        .rstn(rstn),
        .sck(sck),
        .mosi(mosi),
        .ss_n(ss_n),
        .tx_word(tx_word),
        .rx_word(rx_word),
        .rx_count(rx_count),
        .frame_end(frame_end),
        .miso(miso),
        .miso_oe(miso_oe)
    );

    // ****************************************************************
    // frame decode
    // ****************************************************************
    function automatic logic is_cmd(input logic [15:0] w,
                                    input logic rd,
                                    input word14_t addr);
        return w[`FRAME_RW_BIT] == rd && w[14:1] == addr;
    endfunction

    flags_state_t s;
    flags_state_t next_s;

    logic count_bad;
    logic parity_bad;
    logic frame_ok;
    logic do_status;
    logic do_angle;
    logic do_clear;
    logic do_reset;
    logic do_nop;
    logic link_err;

    assign count_bad = frame_end && rx_count != 5'(FRAME_BITS);
    assign parity_bad = frame_end && !count_bad && (^rx_word);
    assign frame_ok = frame_end && !count_bad && !parity_bad;
    assign do_status = frame_ok
        && is_cmd(rx_word, `FRAME_READ, `ADDR_ERROR_STATUS);
    assign do_angle = frame_ok && is_cmd(rx_word, `FRAME_READ, `ADDR_ANGLE);
    assign do_clear = frame_ok
        && is_cmd(rx_word, `FRAME_READ, `ADDR_CLEAR_ERROR);
    assign do_reset = frame_ok
        && is_cmd(rx_word, !`FRAME_READ, `ADDR_MASTER_RESET);
    assign do_nop = frame_ok && rx_word[14:1] == `ADDR_NOP;

    // ****************************************************************
    // status word
    // ****************************************************************
    always_comb begin
        error_status_word = `ESW_RESET;
        error_status_word[`ESW_BUSY_BIT] = (s.meas == MEAS_BUSY);
        error_status_word[`ESW_BAD_ADDR_BIT] = s.bad_address_monitor_flag;
        error_status_word[`ESW_CLK_COUNT_BIT] = s.clock_count_monitor_flag;
        error_status_word[`ESW_PARITY_BIT] = s.parity_flag;
    end

    assign link_err = s.bad_address_monitor_flag
        || s.clock_count_monitor_flag || s.parity_flag;
    assign communication_error_flag = link_err;

    // error flag in every response, even parity over the frame
    assign tx_word = {s.resp, link_err, ^{s.resp, link_err}};

    // ****************************************************************
    // flags and measurement tracking
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.meas_start = 1'b0;
        next_s.meas_abort = 1'b0;
        if (s.meas == MEAS_BUSY && meas_done) begin
            next_s.meas = MEAS_IDLE;
            next_s.resp = angle_word;
        end
        // an angle read while busy is not restarted
        if (do_angle && s.meas == MEAS_IDLE) begin
            next_s.meas = MEAS_BUSY;
            next_s.meas_start = 1'b1;
        end
        if (do_status || do_clear) begin
            next_s.resp = error_status_word;
        end
        if (do_nop) begin
            next_s.resp = `RESP_RESET;
        end
        // sticky until clear; a new error in the same cycle wins
        if (do_clear) begin
            next_s.bad_address_monitor_flag = 1'b0;
            next_s.clock_count_monitor_flag = 1'b0;
            next_s.parity_flag = 1'b0;
        end
        // master reset clears a deadlock and all flags
        if (do_reset) begin
            next_s = '0;
            next_s.meas = MEAS_IDLE;
            next_s.meas_abort = 1'b1;
        end
        if (frame_ok && !(do_status || do_angle || do_clear || do_reset
                || do_nop)) begin
            next_s.bad_address_monitor_flag = 1'b1;
        end
        if (count_bad) begin
            next_s.clock_count_monitor_flag = 1'b1;
        end
        if (parity_bad) begin
            next_s.parity_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.meas <= MEAS_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign meas_start = s.meas_start;
    assign meas_abort = s.meas_abort;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_busy_on_start: assert property (
        meas_start |-> error_status_word[`ESW_BUSY_BIT]
            && $past(do_angle))
        else $error("busy flag not set with measurement start");

    a_busy_clears: assert property (
        error_status_word[`ESW_BUSY_BIT] && meas_done && !do_reset
            |=> !error_status_word[`ESW_BUSY_BIT]
                && s.resp == $past(angle_word))
        else $error("busy flag not cleared on completion");

    a_reset_clears: assert property (
        do_reset |=> !error_status_word[`ESW_BUSY_BIT] && meas_abort
            ##1 !meas_abort)
        else $error("master reset did not clear busy flag");

    a_bad_addr_sets: assert property (
        frame_ok && !(do_status || do_angle || do_clear || do_reset
            || do_nop) |=> error_status_word[`ESW_BAD_ADDR_BIT])
        else $error("bad address flag not set");

    a_clk_count_sets: assert property (
        frame_end && rx_count != 5'h10
            |=> error_status_word[`ESW_CLK_COUNT_BIT])
        else $error("clock count flag not set");

    a_parity_sets: assert property (
        frame_end && rx_count == 5'h10 && (^rx_word)
            |=> error_status_word[`ESW_PARITY_BIT]
                && !$past(do_status))
        else $error("parity flag not set");

    a_reserved_zero: assert property (
        error_status_word[13:5] == 9'h000 && !error_status_word[3])
        else $error("reserved status bit set");

    a_err_flag_sent: assert property (
        link_err && !frame_end |=> tx_word[1] && ^tx_word == 1'b0)
        else $error("response lacks error flag or parity");

    a_status_read: assert property (
        do_status |=> s.resp == $past(error_status_word))
        else $error("status word not loaded for read");

    a_flags_sticky: assert property (
        error_status_word[`ESW_PARITY_BIT] && !do_clear && !do_reset
            |=> error_status_word[`ESW_PARITY_BIT])
        else $error("parity flag dropped without clear");

    c_angle_cycle: cover property (
        meas_start ##[1:200] !error_status_word[`ESW_BUSY_BIT]);
    c_deadlock_reset: cover property (
        error_status_word[`ESW_BUSY_BIT] && do_reset);
    c_clear_errors: cover property (do_clear && link_err);
    c_bad_count: cover property (count_bad);

endmodule
`default_nettype wire

// >>> esw_host.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// serial host: mode 1, every sck level held for several clk cycles
// ****************************************************************
module esw_host (
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    output logic sck,
    output logic mosi,
    output logic ss_n,
    output logic [15:0] rx,
    output logic rx_stb
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
        rx = 16'h0000;
        rx_stb = 1'b0;
    end

    task automatic frame(input logic [15:0] w, input int nbits);
        logic [15:0] r;
        r = 16'h0000;
        @(posedge clk);
        ss_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            sck <= 1'b1;
            mosi <= w[15-i];
            repeat (2) @(posedge clk);
            // sample mid-cycle so the design's miso update cannot race
            @(negedge clk);
            // an undriven miso reads as a flip, never as a lucky match
            r = {r[14:0], miso_oe ? miso : ~r[0]};
            @(posedge clk);
            sck <= 1'b0;
            repeat (2) @(posedge clk);
        end
        ss_n <= 1'b1;
        // released data line shows a changing pattern, not the last bit
        mosi <= ~mosi;
        rx <= r;
        rx_stb <= 1'b1;
        @(posedge clk);
        rx_stb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// >>> sensor_error_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "esw_cfg.svh"

module sensor_error_status_flags_tb;
    import esw_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic meas_done = 1'b0;
    word14_t angle_word = 14'h0000;
    word14_t esw;
    word14_t ang;
    logic sck, mosi, ss_n, miso, miso_oe, meas_start, meas_abort, comm_err;
    logic [15:0] rx;
    logic rx_stb;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_start = 0;
    int n_abort = 0;
    int cyc = 0;
    localparam logic [15:0] ALL = 16'hFFFF;

    always #5 clk = ~clk;

    sensor_error_status_flags sensor_error_status_flags_i (.clk(clk),
        .rstn(rstn), .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso),
        .miso_oe(miso_oe), .meas_start(meas_start), .meas_abort(meas_abort),
        .meas_done(meas_done), .angle_word(angle_word),
        .error_status_word(esw), .communication_error_flag(comm_err));

    esw_host esw_host_i (.clk(clk), .miso(miso), .miso_oe(miso_oe),
        .sck(sck), .mosi(mosi), .ss_n(ss_n), .rx(rx), .rx_stb(rx_stb));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] x,
                       input logic [15:0] g);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask

    function automatic logic [15:0] cmd(input logic rw, input word14_t a);
        cmd = {rw, a, ^{rw, a}};
    endfunction

    function automatic logic [15:0] mk(input word14_t d, input logic f);
        mk = {d, f, ^{d, f}};
    endfunction

    task automatic xfer(input logic [15:0] w, input int n,
                        input logic [15:0] x, input logic [15:0] m);
        exp_q.push_back({m, x});
        esw_host_i.frame(w, n);
    endtask

    task automatic st(input string nm, input word14_t x);
        cmp(nm, {2'b00, x}, {2'b00, esw});
    endtask

    // ****************************************************************
    // response watcher, pulse counters and timeout
    // ****************************************************************
    always @(posedge clk) begin
        cyc++;
        n_start += (meas_start === 1'b1);
        n_abort += (meas_abort === 1'b1);
        if (rx_stb === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp("response", e[15:0] & e[31:16], rx & e[31:16]);
        end
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h8DDD175A));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS), 16, mk(0, 0), ALL);
        xfer(cmd(1'b1, `ADDR_ANGLE), 16, mk(0, 0), ALL);
        st("busy", 14'h0010);
        cmp("starts", 16'h0001, 16'(n_start));
        ang = word14_t'($urandom);
        angle_word <= ang;
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        repeat (3) @(posedge clk);
        st("done", 14'h0000);
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS), 16, mk(ang, 0), ALL);
        xfer(cmd(1'b1, 14'h1234), 16, mk(0, 0), ALL);
        st("bad address", 14'h0004);
        // a short frame only sees the top 15 bits of the response
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS), 15, mk(0, 1) >> 1, ALL);
        st("clock count", 14'h0006);
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS) ^ 16'h0001, 16, mk(0, 1),
            ALL);
        st("parity", 14'h0007);
        cmp("flag", 16'h0001, {15'h0000, comm_err});
        repeat (40) @(posedge clk);
        st("held", 14'h0007);
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS), 16, mk(0, 1), ALL);
        xfer(cmd(1'b1, `ADDR_CLEAR_ERROR), 16, mk(7, 1), ALL);
        st("cleared", 14'h0000);
        cmp("flag", 16'h0000, {15'h0000, comm_err});
        xfer(`ADDR_NOP, 16, mk(7, 0), ALL);
        // no second angle read is sent while busy
        xfer(cmd(1'b1, `ADDR_ANGLE), 16, mk(0, 0), ALL);
        repeat (60) @(posedge clk);
        st("stuck", 14'h0010);
        cmp("starts", 16'h0002, 16'(n_start));
        xfer(cmd(1'b0, `ADDR_MASTER_RESET), 16, mk(0, 0), ALL);
        st("unstuck", 14'h0000);
        cmp("aborts", 16'h0001, 16'(n_abort));
        xfer(cmd(1'b1, `ADDR_ERROR_STATUS), 16, mk(0, 0), ALL);
        repeat (4) @(posedge clk);
        cmp("pending", 16'h0000, 16'(exp_q.size()));
        wrap_up();
    end
endmodule

`default_nettype wire
